// ===== core/ca_consts.svh
`ifndef CA_CONSTS_SVH
`define CA_CONSTS_SVH

// Register indices on the special-function port
`define ADDR_CTRL 8'h00
`define ADDR_MODE 8'h01
`define ADDR_CNT_LO 8'h02
`define ADDR_CNT_HI 8'h03
`define ADDR_MMODE_BASE 8'h10
`define ADDR_CMPL_BASE 8'h20
`define ADDR_CMPH_BASE 8'h30

// Control register fields
`define CTRL_OVF_BIT 7
`define CTRL_RUN_BIT 6

// Counter array mode register fields
`define MODE_IDLE_BIT 7
`define MODE_TB_LSB 1
`define MODE_OVF_IE_BIT 0
`define MODE_WMASK 8'h8f

// Module mode register fields
`define MM_WIDE_BIT 7
`define MM_ECOM_BIT 6
`define MM_CAPP_BIT 5
`define MM_CAPN_BIT 4
`define MM_MAT_BIT 3
`define MM_TOG_BIT 2
`define MM_PWM_BIT 1
`define MM_ECCF_BIT 0

// Reset values
`define CTRL_RESET 8'h00
`define MODE_RESET 8'h00
`define MMODE_RESET 8'h00
`define CMP_RESET 8'h00

// Timebase select codes and divider counts
`define TB_DIV12 3'h0
`define TB_DIV4 3'h1
`define TB_TIMER0 3'h2
`define TB_EXT_FALL 3'h3
`define TB_SYSCLK 3'h4
`define TB_OSC_DIV8 3'h5
`define DIV_SLOW 4'hc
`define DIV_FAST 4'h4
`define OSC_DIV_LAST 3'h7

`endif

// ===== core/ca_pkg.sv
package ca_pkg;
`include "ca_consts.svh"

  typedef enum {CM_OFF, CM_SW_TIMER, CM_FAST_OUT, CM_FREQ, CM_PWM8, CM_PWM16} cmp_mode_t;

  function automatic cmp_mode_t decode_mode(input logic [7:0] m);
    cmp_mode_t r;
    r = CM_OFF;
    if (m[`MM_ECOM_BIT] && !m[`MM_CAPP_BIT] && !m[`MM_CAPN_BIT]) begin
      unique case ({m[`MM_MAT_BIT], m[`MM_TOG_BIT], m[`MM_PWM_BIT]})
        3'b100: r = CM_SW_TIMER;
        3'b110: r = CM_FAST_OUT;
        3'b011: r = CM_FREQ;
        3'b001: r = m[`MM_WIDE_BIT] ? CM_PWM16 : CM_PWM8;
        default: r = CM_OFF;
      endcase
    end
    return r;
  endfunction : decode_mode
endpackage : ca_pkg

// ===== core/timebase_gen.sv
`timescale 1ns/1ps
`include "ca_consts.svh"
module timebase_gen
  import ca_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Source selection and sources
  input wire logic [2:0] select,
  input wire logic timer0_overflow,
  input wire logic ext_count_pin,
  input wire logic ext_osc_pin,
  // Counter advance pulse
  output logic tick_reg
);
  logic [3:0] div_reg;
  logic [3:0] div_limit;
  logic ext_meta_reg, ext_sync_reg, ext_prev_reg;
  logic osc_meta_reg, osc_sync_reg, osc_prev_reg;
  logic [2:0] osc_div_reg;
  logic div_hit, ext_fall, osc_rise, tick_next;

  assign div_limit = (select == `TB_DIV4) ? `DIV_FAST : `DIV_SLOW;
  assign div_hit = (div_reg == div_limit - 4'h1);
  assign ext_fall = ext_prev_reg && !ext_sync_reg;
  assign osc_rise = osc_sync_reg && !osc_prev_reg;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) div_reg <= 4'h0;
    else if (div_hit || div_reg >= div_limit) div_reg <= 4'h0;
    else div_reg <= div_reg + 4'h1;
  end

  // Pins are foreign to clk_sys: two flops before any use
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      {ext_meta_reg, ext_sync_reg, ext_prev_reg} <= 3'h7;
      {osc_meta_reg, osc_sync_reg, osc_prev_reg} <= 3'h0;
    end else begin
      {ext_meta_reg, ext_sync_reg, ext_prev_reg} <= {ext_count_pin, ext_meta_reg, ext_sync_reg};
      {osc_meta_reg, osc_sync_reg, osc_prev_reg} <= {ext_osc_pin, osc_meta_reg, osc_sync_reg};
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) osc_div_reg <= 3'h0;
    else if (osc_rise) osc_div_reg <= osc_div_reg + 3'h1;
  end

  always_comb begin
    unique case (select)
      `TB_DIV12, `TB_DIV4: tick_next = div_hit;
      `TB_TIMER0: tick_next = timer0_overflow;
      `TB_EXT_FALL: tick_next = ext_fall;
      `TB_SYSCLK: tick_next = 1'b1;
      `TB_OSC_DIV8: tick_next = osc_rise && (osc_div_reg == `OSC_DIV_LAST);
      default: tick_next = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) tick_reg <= 1'b0;
    else tick_reg <= tick_next;
  end
endmodule : timebase_gen

// ===== core/compare_unit.sv
`timescale 1ns/1ps
`include "ca_consts.svh"
module compare_unit
  import ca_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Register writes
  input wire logic [7:0] wdata,
  input wire logic mode_wr,
  input wire logic low_wr,
  input wire logic high_wr,
  // Shared counter, valid on the cycle after it moved
  input wire logic [15:0] count,
  input wire logic step,
  input wire logic low_wrap,
  // Register contents and results
  output logic [7:0] mode_reg,
  output logic [7:0] low_reg,
  output logic [7:0] high_reg,
  output logic pin_reg,
  output logic match_reg
);
  cmp_mode_t mode;
  logic m16, m8;

  assign mode = decode_mode(mode_reg);
  assign m16 = step && (count == {high_reg, low_reg});
  assign m8 = step && (count[7:0] == low_reg);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) mode_reg <= `MMODE_RESET;
    else if (mode_wr) mode_reg <= wdata;
    else if (low_wr) mode_reg[`MM_ECOM_BIT] <= 1'b0;
    else if (high_wr) mode_reg[`MM_ECOM_BIT] <= 1'b1;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) high_reg <= `CMP_RESET;
    else if (high_wr) high_reg <= wdata;
  end

  // Software writes win over the hardware updates of the low byte
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) low_reg <= `CMP_RESET;
    else if (low_wr) low_reg <= wdata;
    else if (mode == CM_FREQ && m8) low_reg <= low_reg + high_reg;
    else if (mode == CM_PWM8 && low_wrap) low_reg <= high_reg;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) pin_reg <= 1'b0;
    else begin
      unique case (mode)
        CM_FAST_OUT: if (m16) pin_reg <= !pin_reg;
        CM_FREQ: if (m8) pin_reg <= !pin_reg;
        // Duty (256-H)/256: a zero high byte keeps the pin high
        CM_PWM8: if (low_wrap) pin_reg <= (high_reg == 8'h00);
          else if (m8) pin_reg <= 1'b1;
        CM_PWM16: if (m16) pin_reg <= 1'b1;
          else if (step && count == 16'h0000) pin_reg <= 1'b0;
        CM_SW_TIMER, CM_OFF: pin_reg <= pin_reg;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) match_reg <= 1'b0;
    else match_reg <= m16 && (mode == CM_SW_TIMER || mode == CM_FAST_OUT || mode == CM_PWM16);
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  a_timer_match: assert property (mode == CM_SW_TIMER && m16 |=> match_reg)
    else $error("software timer match not flagged");
  a_fast_toggle: assert property (mode == CM_FAST_OUT && m16 |=> pin_reg != $past(pin_reg))
    else $error("fast output did not toggle");
  a_freq_advance: assert property (mode == CM_FREQ && m8 && !low_wr
    |=> low_reg == 8'($past(low_reg) + $past(high_reg)))
    else $error("frequency offset not added");
  a_pwm8_reload: assert property (mode == CM_PWM8 && low_wrap && !low_wr |=> low_reg == $past(high_reg))
    else $error("pwm8 reload missing");
  a_pwm16_fall: assert property (mode == CM_PWM16 && step && count == 16'h0000 && !m16 |=> !pin_reg)
    else $error("pwm16 output not low at overflow");
  a_low_clears: assert property (low_wr && !mode_wr |=> !mode_reg[`MM_ECOM_BIT])
    else $error("low byte write kept compare enable");
  a_high_sets: assert property (high_wr && !mode_wr && !low_wr |=> mode_reg[`MM_ECOM_BIT])
    else $error("high byte write did not set compare enable");
  c_freq_toggle: cover property (mode == CM_FREQ && m8);
  c_pwm16_rise: cover property (mode == CM_PWM16 && m16);
endmodule : compare_unit

// ===== core/counter_array_compare_pwm.sv
`timescale 1ns/1ps
`include "ca_consts.svh"
// Notes on behaviour
// - Timer mode: counter equals compare sets flag
// - Set flag with enable raises interrupt request
// - Flags stay set until software clears
// - Timer mode needs compare and match enables
// - Low write clears, high write sets enable
// - Fast output mode toggles pin on match
// - Frequency mode: low match toggles, adds high
// - Square wave period is twice high byte
// - Zero high byte means 256 clocks
// - Frequency mode needs compare, toggle, pwm bits
// - PWM8 high on low match, low on wrap
// - PWM8 reloads low byte from high byte
// - PWM8 needs compare, pwm; wide select clear
// - PWM8 duty is (256 - high)/256
// - PWM16 high on match, low on overflow
// - PWM16 needs compare, pwm, wide select set
// - PWM16 duty is (65536 - compare)/65536
// - Counter wrap sets the overflow flag
// - Timebase select picks the counter advance rate
module counter_array_compare_pwm
  import ca_pkg::*;
#(
  parameter int NUM_MODULES = 6
)(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Special-function register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata_reg,
  // Timebase sources
  input wire logic timer0_overflow,
  input wire logic ext_count_pin,
  input wire logic ext_osc_pin,
  // Module outputs and interrupt
  output logic [NUM_MODULES-1:0] module_output_pin,
  output logic irq_req_reg
);
  localparam int NM = NUM_MODULES;

  if (NUM_MODULES < 1 || NUM_MODULES > 6) begin : g_check
    $error("NUM_MODULES must be 1 to 6");
  end

  logic [15:0] count_reg;
  logic [7:0] snap_reg;
  logic [7:0] mode_reg;
  logic run_reg;
  logic ovf_reg;
  logic [5:0] flags_reg;
  logic step_reg;
  logic wrap_reg;
  logic tick;

  logic [7:0] mm [NM];
  logic [7:0] cl [NM];
  logic [7:0] ch [NM];
  logic [NM-1:0] match_evt;
  logic [NM-1:0] eccf;
  logic [5:0] flag_set;
  logic [5:0] eccf6;

  logic ctrl_wr, mode_wr, lo_wr, hi_wr;
  logic run_step, ovf_set;

  // Returns one-hot selects for a per-module register bank
  function automatic logic [NM-1:0] bank_sel(input logic [7:0] addr, input logic [7:0] base);
    logic [NM-1:0] s;
    s = '0;
    for (int i = 0; i < NM; i++) begin
      if (addr == base + 8'(i)) s[i] = 1'b1;
    end
    return s;
  endfunction : bank_sel

  logic [NM-1:0] mm_wr, cl_wr, ch_wr;

  assign ctrl_wr = sfr_wr && sfr_addr == `ADDR_CTRL;
  assign mode_wr = sfr_wr && sfr_addr == `ADDR_MODE;
  assign lo_wr = sfr_wr && sfr_addr == `ADDR_CNT_LO;
  assign hi_wr = sfr_wr && sfr_addr == `ADDR_CNT_HI;
  assign mm_wr = sfr_wr ? bank_sel(sfr_addr, `ADDR_MMODE_BASE) : '0;
  assign cl_wr = sfr_wr ? bank_sel(sfr_addr, `ADDR_CMPL_BASE) : '0;
  assign ch_wr = sfr_wr ? bank_sel(sfr_addr, `ADDR_CMPH_BASE) : '0;

  assign run_step = tick && run_reg;
  assign ovf_set = run_step && !lo_wr && !hi_wr && count_reg == 16'hffff;

  timebase_gen u_timebase (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .select(mode_reg[`MODE_TB_LSB +: 3]),
    .timer0_overflow(timer0_overflow),
    .ext_count_pin(ext_count_pin),
    .ext_osc_pin(ext_osc_pin),
    .tick_reg(tick)
  );

  for (genvar g = 0; g < NM; g++) begin : g_mod
    compare_unit u_unit (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .wdata(sfr_wdata),
      .mode_wr(mm_wr[g]),
      .low_wr(cl_wr[g]),
      .high_wr(ch_wr[g]),
      .count(count_reg),
      .step(step_reg),
      .low_wrap(wrap_reg),
      .mode_reg(mm[g]),
      .low_reg(cl[g]),
      .high_reg(ch[g]),
      .pin_reg(module_output_pin[g]),
      .match_reg(match_evt[g])
    );
    assign eccf[g] = mm[g][`MM_ECCF_BIT];
  end

  assign flag_set = 6'(match_evt);
  assign eccf6 = 6'(eccf);

  // Shared counter
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) count_reg <= 16'h0000;
    else if (lo_wr) count_reg[7:0] <= sfr_wdata;
    else if (hi_wr) count_reg[15:8] <= sfr_wdata;
    else if (run_step) count_reg <= count_reg + 16'h0001;
  end

  // Compare units look one cycle after the counter moved
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      step_reg <= 1'b0;
      wrap_reg <= 1'b0;
    end else begin
      step_reg <= run_step && !lo_wr && !hi_wr;
      wrap_reg <= run_step && !lo_wr && !hi_wr && count_reg[7:0] == 8'hff;
    end
  end

  // Reading the low byte freezes the high byte for the next read
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) snap_reg <= 8'h00;
    else if (sfr_rd && sfr_addr == `ADDR_CNT_LO) snap_reg <= count_reg[15:8];
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) mode_reg <= `MODE_RESET;
    else if (mode_wr) mode_reg <= sfr_wdata & `MODE_WMASK;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) run_reg <= 1'(`CTRL_RESET >> `CTRL_RUN_BIT);
    else if (ctrl_wr) run_reg <= sfr_wdata[`CTRL_RUN_BIT];
  end

  // Hardware set wins over a software clear in the same cycle
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) ovf_reg <= 1'b0;
    else if (ovf_set) ovf_reg <= 1'b1;
    else if (ctrl_wr) ovf_reg <= sfr_wdata[`CTRL_OVF_BIT];
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) flags_reg <= 6'h00;
    else if (ctrl_wr) flags_reg <= sfr_wdata[5:0] | flag_set;
    else flags_reg <= flags_reg | flag_set;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) irq_req_reg <= 1'b0;
    else irq_req_reg <= |(flags_reg & eccf6) || (ovf_reg && mode_reg[`MODE_OVF_IE_BIT]);
  end

  // Register read port
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) sfr_rdata_reg <= 8'h00;
    else if (sfr_rd) begin
      sfr_rdata_reg <= 8'h00;
      if (sfr_addr == `ADDR_CTRL) sfr_rdata_reg <= {ovf_reg, run_reg, flags_reg};
      if (sfr_addr == `ADDR_MODE) sfr_rdata_reg <= mode_reg;
      if (sfr_addr == `ADDR_CNT_LO) sfr_rdata_reg <= count_reg[7:0];
      if (sfr_addr == `ADDR_CNT_HI) sfr_rdata_reg <= snap_reg;
      for (int i = 0; i < NM; i++) begin
        if (sfr_addr == `ADDR_MMODE_BASE + 8'(i)) sfr_rdata_reg <= mm[i];
        if (sfr_addr == `ADDR_CMPL_BASE + 8'(i)) sfr_rdata_reg <= cl[i];
        if (sfr_addr == `ADDR_CMPH_BASE + 8'(i)) sfr_rdata_reg <= ch[i];
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  a_ovf_wrap: assert property (ovf_set |=> ovf_reg ##0 count_reg == 16'h0000)
    else $error("counter wrap did not set overflow");
  a_cnt_hold: assert property (!run_reg && !lo_wr && !hi_wr |=> $stable(count_reg))
    else $error("counter moved while stopped");
  a_cnt_step: assert property (run_step && !lo_wr && !hi_wr |=> count_reg == 16'($past(count_reg) + 16'h0001))
    else $error("counter did not advance on tick");
  a_flag_sticky: assert property (!ctrl_wr |=> (flags_reg & $past(flags_reg)) == $past(flags_reg))
    else $error("match flag cleared by hardware");
  a_flag_from_match: assert property (flag_set != 6'h00 |=> (flags_reg & $past(flag_set)) == $past(flag_set))
    else $error("match event lost");
  a_irq_raise: assert property ((flags_reg & eccf6) != 6'h00 |=> irq_req_reg)
    else $error("enabled flag raised no interrupt");
  a_ctrl_read: assert property (sfr_rd && sfr_addr == `ADDR_CTRL
    |=> sfr_rdata_reg == {$past(ovf_reg), $past(run_reg), $past(flags_reg)})
    else $error("control read wrong");
  c_overflow: cover property (ovf_set);
  c_flag_irq: cover property (irq_req_reg && flags_reg != 6'h00);
  c_stop_run: cover property (run_reg ##1 !run_reg ##1 run_reg);
endmodule : counter_array_compare_pwm

// ===== verif/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import ca_pkg::*;
;
  logic clk_sys;
  logic reset_n;
  logic [7:0] sfr_addr;
  logic sfr_wr;
  logic sfr_rd;
  logic [7:0] sfr_wdata;
  logic [7:0] sfr_rdata_reg;
  logic timer0_overflow;
  logic ext_count_pin;
  logic ext_osc_pin;
  logic [5:0] module_output_pin;
  logic irq_req_reg;
  int err_count;
  int num_checks;
  logic [39:0] reg_rows [0:15];
  logic [23:0] tb_rows [0:5];
  logic [7:0] d;
  logic [7:0] c0;
  int n;

  counter_array_compare_pwm #(.NUM_MODULES(6)) i_dut (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata),
    .sfr_rdata_reg(sfr_rdata_reg),
    .timer0_overflow(timer0_overflow),
    .ext_count_pin(ext_count_pin),
    .ext_osc_pin(ext_osc_pin),
    .module_output_pin(module_output_pin),
    .irq_req_reg(irq_req_reg)
  );

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask : cyc

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    sfr_addr = a;
    sfr_wdata = v;
    sfr_wr = 1'b1;
    cyc(1);
    sfr_wr = 1'b0;
    cyc(1);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    sfr_addr = a;
    sfr_rd = 1'b1;
    cyc(1);
    sfr_rd = 1'b0;
    v = sfr_rdata_reg;
    cyc(1);
  endtask : rd

  task automatic set_cnt(input logic [15:0] v);
    wr(8'h02, v[7:0]);
    wr(8'h03, v[15:8]);
  endtask : set_cnt

  // Toggle a source pin 2*k times, slow enough for the synchronisers
  task automatic pin_edges(input int sel, input int k);
    for (int i = 0; i < 2 * k; i++) begin
      if (sel == 3) ext_count_pin = ~ext_count_pin;
      else ext_osc_pin = ~ext_osc_pin;
      cyc(3);
    end
  endtask : pin_edges

  task automatic count_high(input int idx, input int span, output int cnt);
    cnt = 0;
    for (int i = 0; i < span; i++) begin
      cyc(1);
      if (module_output_pin[idx] === 1'b1) cnt++;
    end
  endtask : count_high

  // Cycles between two consecutive changes of one output
  task automatic half(input int idx, output int cnt);
    logic p;
    int k;
    k = 0;
    cnt = 0;
    p = module_output_pin[idx];
    while (module_output_pin[idx] === p && k < 600) begin
      cyc(1);
      k++;
    end
    p = module_output_pin[idx];
    while (module_output_pin[idx] === p && cnt < 600) begin
      cyc(1);
      cnt++;
    end
  endtask : half

  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize

  initial begin
    cyc(20000);
    err_count++;
    summarize();
  end

  initial begin
    err_count = 0;
    num_checks = 0;
    reset_n = 1'b0;
    sfr_addr = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_wdata = 8'h00;
    timer0_overflow = 1'b0;
    ext_count_pin = 1'b0;
    ext_osc_pin = 1'b0;
    // Write flag, write address, write data, read address, expected read
    reg_rows = '{40'h00_00_00_00_00, 40'h00_00_00_01_00, 40'h00_00_00_15_00, 40'h00_00_00_25_00,
                 40'h00_00_00_35_00, 40'h01_15_48_15_48, 40'h01_25_12_15_08, 40'h01_35_34_15_48,
                 40'h00_00_00_25_12, 40'h00_00_00_35_34, 40'h01_01_ff_01_8f, 40'h01_01_00_01_00,
                 40'h01_77_5a_77_00, 40'h01_00_3f_00_3f, 40'h01_00_00_00_00, 40'h01_15_00_15_00};
    // Timebase select, events or cycles, expected counter advance
    tb_rows = '{24'h04_32_32, 24'h01_28_0a, 24'h00_78_0a, 24'h02_05_05, 24'h03_06_06, 24'h05_40_08};
    repeat (6) @(posedge clk_sys);
    #1;
    reset_n = 1'b1;
    chk({10'h000, module_output_pin}, 16'h0000, "outputs after reset");
    chk({15'h0000, irq_req_reg}, 16'h0000, "irq after reset");
    for (int i = 0; i < 16; i++) begin
      if (reg_rows[i][32]) wr(reg_rows[i][31:24], reg_rows[i][23:16]);
      rd(reg_rows[i][15:8], d);
      chk({8'h00, d}, {8'h00, reg_rows[i][7:0]}, "register row");
    end

    // Software timer on module 0, module 4 lacks its compare enable
    wr(8'h24, 8'h10);
    wr(8'h34, 8'h00);
    wr(8'h14, 8'h08);
    wr(8'h10, 8'h49);
    wr(8'h20, 8'h10);
    wr(8'h30, 8'h00);
    set_cnt(16'h0000);
    wr(8'h01, 8'h08);
    wr(8'h00, 8'h40);
    cyc(30);
    rd(8'h00, d);
    chk({8'h00, d}, 16'h0041, "timer flag");
    chk({15'h0000, irq_req_reg}, 16'h0001, "timer irq");
    cyc(20);
    rd(8'h00, d);
    chk({8'h00, d}, 16'h0041, "flag held");
    wr(8'h00, 8'h00);
    rd(8'h00, d);
    chk({8'h00, d}, 16'h0000, "flag cleared");
    chk({15'h0000, irq_req_reg}, 16'h0000, "irq dropped");
    wr(8'h10, 8'h00);
    wr(8'h14, 8'h00);

    // Counter advance for every timebase source
    wr(8'h00, 8'h40);
    for (int i = 0; i < 6; i++) begin
      wr(8'h01, {4'h0, tb_rows[i][18:16], 1'b0});
      cyc(3);
      rd(8'h02, c0);
      case (tb_rows[i][18:16])
        3'h2: begin
          timer0_overflow = 1'b1;
          cyc(tb_rows[i][15:8]);
          timer0_overflow = 1'b0;
          cyc(12);
        end
        3'h3, 3'h5: begin
          pin_edges(tb_rows[i][18:16], tb_rows[i][15:8]);
          cyc(12);
        end
        default: cyc(tb_rows[i][15:8] - 2);
      endcase
      rd(8'h02, d);
      chk({8'h00, d - c0}, {8'h00, tb_rows[i][7:0]}, "timebase advance");
    end

    // Counter frozen while stopped
    wr(8'h01, 8'h08);
    wr(8'h00, 8'h00);
    rd(8'h02, c0);
    cyc(20);
    rd(8'h02, d);
    chk({8'h00, d}, {8'h00, c0}, "stopped counter");

    // Overflow flag on wrap
    set_cnt(16'hfffa);
    wr(8'h00, 8'h40);
    cyc(15);
    rd(8'h00, d);
    chk({8'h00, d & 8'hc0}, 16'h00c0, "overflow flag");

    // Fast output toggle on module 1
    wr(8'h00, 8'h00);
    wr(8'h11, 8'h4c);
    wr(8'h21, 8'h20);
    wr(8'h31, 8'h00);
    set_cnt(16'h0000);
    wr(8'h00, 8'h40);
    cyc(16);
    chk({15'h0000, module_output_pin[1]}, 16'h0000, "fast out before match");
    cyc(30);
    chk({15'h0000, module_output_pin[1]}, 16'h0001, "fast out after match");

    // Frequency output on module 2
    wr(8'h12, 8'h46);
    wr(8'h22, 8'h08);
    wr(8'h32, 8'h04);
    half(2, n);
    half(2, n);
    chk(n[15:0], 16'h0004, "freq half period");
    wr(8'h32, 8'h00);
    half(2, n);
    half(2, n);
    chk(n[15:0], 16'h0100, "freq zero step");
    wr(8'h12, 8'h00);

    // Eight-bit PWM on module 3, reload moves duty from 0x10 to 0xc0
    wr(8'h13, 8'h42);
    wr(8'h23, 8'h10);
    wr(8'h33, 8'hc0);
    cyc(300);
    count_high(3, 512, n);
    chk(n[15:0], 16'h0080, "pwm8 high time");

    // Sixteen-bit PWM on module 4 across a wrap
    wr(8'h00, 8'h00);
    wr(8'h14, 8'hc3);
    wr(8'h24, 8'h80);
    wr(8'h34, 8'hff);
    set_cnt(16'hff00);
    wr(8'h00, 8'h40);
    count_high(4, 400, n);
    chk(n[15:0], 16'h0080, "pwm16 high time");
    summarize();
  end
endmodule : tb_top
